// [rtl/fosc_pkg.sv]
/*
  Constants, carrier types and state codes for the serial frequency
  offset command interpreter.
  Assumes a single 40 MHz clock domain and 8N1 asynchronous framing.
*/
package fosc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ   = 40_000_000;
  localparam int unsigned BAUD     = 9600;

  // ----------------------------------------------------------------
  // Message framing
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_SET_SAVE = 8'h2C;
  localparam logic [7:0]  CMD_READ     = 8'h2D;
  localparam logic [7:0]  CMD_SET_TEMP = 8'h2E;
  localparam logic [15:0] LEN_HDR      = 16'h0004;
  localparam logic [15:0] LEN_OFS      = 16'h0009;
  localparam logic [7:0]  RESP_CHK     = 8'h24;
  localparam logic [3:0]  IDX_HCHK     = 4'h3;
  localparam logic [3:0]  IDX_DCHK     = 4'h4;
  localparam logic [3:0]  IDX_RLAST    = 4'h8;
  localparam logic [3:0]  IDX_STOP     = 4'h9;

  // ----------------------------------------------------------------
  // Offset scaling and reset
  // ----------------------------------------------------------------
  localparam logic [31:0] OFFSET_RST   = 32'h0000_0000;
  localparam real         STEP_HZ      = 1.7854e-7;
  localparam real         SPAN_HZ      = 383.0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  cmd;
    logic [15:0] len;
  } fosc_hdr_t;

  typedef enum logic [2:0] {
    ST_HDR  = 3'b001,
    ST_DATA = 3'b010,
    ST_SEND = 3'b100
  } fosc_state_t;

endpackage : fosc_pkg

// [rtl/fosc_cmd.sv]
/*
  Serial command interpreter: receives framed messages on an 8N1 line,
  sets or reads back a signed 32-bit frequency offset, requests
  nonvolatile saves.
  Assumes NV_OFFSET holds the stored offset, stable in the CLK domain
  by the first enabled cycle after reset release.
*/
// Operation
// - Header: command, length low, length high, header check byte.
// - Header check equals XOR of header bytes 0, 1 and 2.
// - Data bytes follow the header check directly; count per command.
// - A data check byte, XOR of all data bytes, follows data.
// - Length counts whole message; data-less message has length four.
// - Command 0x2C, length 9: apply offset and save it nonvolatile.
// - Offset is signed 32-bit, most significant byte first.
// - Command 0x2E, length 9: apply offset without saving.
// - Non-saving offset command accepted at any rate.
// - Read request: 0x2D, length 4, header check 0x29, no data.
// - Read answer: 0x2D, 9, 0x24, offset MSB first, data check.
// - Each offset step moves output by 1.7854E-7 Hz.
// - Full-scale codes map to about +383 Hz and -383 Hz.
// - Host sends on its transmit line; device answers on the other.
`timescale 1ns/1ps
module fosc_cmd #(
  parameter int unsigned CLKS_PER_BIT = fosc_pkg::CLK_HZ / fosc_pkg::BAUD
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        CE,
  input  wire logic        RX_PIN,
  output logic             TX_PIN,
  input  wire logic [31:0] NV_OFFSET,
  output logic      [31:0] OFFSET,
  output logic             OFFSET_STB,
  output logic             NV_WRITE,
  output logic      [31:0] NV_DATA
);

  localparam logic [15:0] BIT_LAST  = 16'(CLKS_PER_BIT - 1);
  localparam logic [15:0] HALF_LAST = 16'(CLKS_PER_BIT / 2 - 1);

  // ----------------------------------------------------------------
  // Receiver, 8N1, sampled mid-bit
  // ----------------------------------------------------------------
  logic        rx_s1_q, rx_s2_q, rx_busy_q, rx_vld_q;
  logic [15:0] rx_cnt_q;
  logic [3:0]  rx_bit_q;
  logic [7:0]  rx_sh_q, rx_byte_q;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rx_s1_q   <= 1'b1;
      rx_s2_q   <= 1'b1;
      rx_busy_q <= 1'b0;
      rx_vld_q  <= 1'b0;
      rx_cnt_q  <= 16'h0000;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h00;
      rx_byte_q <= 8'h00;
    end else if (CE) begin
      rx_s1_q  <= RX_PIN;
      rx_s2_q  <= rx_s1_q;
      rx_vld_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rx_s2_q) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q  <= HALF_LAST;
          rx_bit_q  <= 4'h0;
        end
      end else if (rx_cnt_q != 16'h0000) begin
        rx_cnt_q <= rx_cnt_q - 16'h0001;
      end else begin
        rx_cnt_q <= BIT_LAST;
        rx_bit_q <= rx_bit_q + 4'h1;
        // Glitch shorter than half a bit is not a start bit
        if (rx_bit_q == 4'h0 && rx_s2_q) begin
          rx_busy_q <= 1'b0;
        end else if (rx_bit_q == fosc_pkg::IDX_STOP) begin
          rx_busy_q <= 1'b0;
          rx_vld_q  <= rx_s2_q;
          rx_byte_q <= rx_sh_q;
        end else if (rx_bit_q != 4'h0) begin
          rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmitter, 8N1
  // ----------------------------------------------------------------
  logic        tx_busy_q, tx_ld;
  logic [15:0] tx_cnt_q;
  logic [3:0]  tx_bit_q;
  logic [9:0]  tx_sh_q;
  logic [7:0]  tx_byte;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      tx_busy_q <= 1'b0;
      tx_cnt_q  <= 16'h0000;
      tx_bit_q  <= 4'h0;
      tx_sh_q   <= 10'h3FF;
    end else if (CE) begin
      if (tx_ld) begin
        tx_sh_q   <= {1'b1, tx_byte, 1'b0};
        tx_cnt_q  <= BIT_LAST;
        tx_bit_q  <= 4'h0;
        tx_busy_q <= 1'b1;
      end else if (tx_busy_q) begin
        if (tx_cnt_q != 16'h0000) begin
          tx_cnt_q <= tx_cnt_q - 16'h0001;
        end else begin
          tx_cnt_q <= BIT_LAST;
          tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
          tx_bit_q <= tx_bit_q + 4'h1;
          if (tx_bit_q == fosc_pkg::IDX_STOP) begin
            tx_busy_q <= 1'b0;
          end
        end
      end
    end
  end

  assign TX_PIN = tx_sh_q[0];

  // ----------------------------------------------------------------
  // Message parser
  // ----------------------------------------------------------------
  fosc_pkg::fosc_state_t st_q;
  fosc_pkg::fosc_hdr_t   hdr_q;
  logic [3:0]  idx_q;
  logic [7:0]  xor_q;
  logic [31:0] data_q, offset_q;
  logic        init_q, stb_q, nvw_q;

  wire hdr_ok   = rx_byte_q == xor_q;
  wire is_read  = hdr_q.cmd == fosc_pkg::CMD_READ &&
                  hdr_q.len == fosc_pkg::LEN_HDR;
  wire is_set   = (hdr_q.cmd == fosc_pkg::CMD_SET_SAVE ||
                   hdr_q.cmd == fosc_pkg::CMD_SET_TEMP) &&
                  hdr_q.len == fosc_pkg::LEN_OFS;
  wire hdr_end  = st_q == fosc_pkg::ST_HDR && rx_vld_q &&
                  idx_q == fosc_pkg::IDX_HCHK;
  wire data_end = st_q == fosc_pkg::ST_DATA && rx_vld_q &&
                  idx_q == fosc_pkg::IDX_DCHK;

  // Answer byte by position; data check is XOR of the four offset bytes
  function automatic logic [7:0] resp_byte(input logic [3:0]  i,
                                           input logic [31:0] v);
    case (i)
      4'h0:    resp_byte = fosc_pkg::CMD_READ;
      4'h1:    resp_byte = fosc_pkg::LEN_OFS[7:0];
      4'h2:    resp_byte = fosc_pkg::LEN_OFS[15:8];
      4'h3:    resp_byte = fosc_pkg::RESP_CHK;
      4'h4:    resp_byte = v[31:24];
      4'h5:    resp_byte = v[23:16];
      4'h6:    resp_byte = v[15:8];
      4'h7:    resp_byte = v[7:0];
      default: resp_byte = v[31:24] ^ v[23:16] ^ v[15:8] ^ v[7:0];
    endcase
  endfunction : resp_byte

  assign tx_ld   = st_q == fosc_pkg::ST_SEND && !tx_busy_q;
  assign tx_byte = resp_byte(idx_q, offset_q);

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st_q     <= fosc_pkg::ST_HDR;
      hdr_q    <= '0;
      idx_q    <= 4'h0;
      xor_q    <= 8'h00;
      data_q   <= 32'h0000_0000;
      offset_q <= fosc_pkg::OFFSET_RST;
      init_q   <= 1'b0;
      stb_q    <= 1'b0;
      nvw_q    <= 1'b0;
    end else if (CE) begin
      stb_q <= 1'b0;
      nvw_q <= 1'b0;
      // Stored offset restored once after power-up
      if (!init_q) begin
        init_q   <= 1'b1;
        offset_q <= NV_OFFSET;
      end
      case (st_q)
        fosc_pkg::ST_HDR: begin
          if (rx_vld_q && init_q) begin
            idx_q <= idx_q + 4'h1;
            xor_q <= (idx_q == 4'h0) ? rx_byte_q : xor_q ^ rx_byte_q;
            case (idx_q)
              4'h0:    hdr_q.cmd       <= rx_byte_q;
              4'h1:    hdr_q.len[7:0]  <= rx_byte_q;
              4'h2:    hdr_q.len[15:8] <= rx_byte_q;
              default: begin
                idx_q <= 4'h0;
                xor_q <= 8'h00;
                if (hdr_ok && is_read) begin
                  st_q <= fosc_pkg::ST_SEND;
                end else if (hdr_ok && is_set) begin
                  st_q <= fosc_pkg::ST_DATA;
                end
                // Anything else is dropped here
              end
            endcase
          end
        end
        fosc_pkg::ST_DATA: begin
          if (rx_vld_q) begin
            idx_q <= idx_q + 4'h1;
            if (idx_q == fosc_pkg::IDX_DCHK) begin
              idx_q <= 4'h0;
              st_q  <= fosc_pkg::ST_HDR;
              if (hdr_ok) begin
                // No rate limit on applying an offset
                offset_q <= data_q;
                stb_q    <= 1'b1;
                nvw_q    <= hdr_q.cmd == fosc_pkg::CMD_SET_SAVE;
              end
            end else begin
              data_q <= {data_q[23:0], rx_byte_q};
              xor_q  <= xor_q ^ rx_byte_q;
            end
          end
        end
        fosc_pkg::ST_SEND: begin
          // Bytes arriving before the last answer byte is loaded are not parsed
          if (tx_ld) begin
            idx_q <= idx_q + 4'h1;
            if (idx_q == fosc_pkg::IDX_RLAST) begin
              idx_q <= 4'h0;
              st_q  <= fosc_pkg::ST_HDR;
            end
          end
        end
        default: begin
          st_q  <= fosc_pkg::ST_HDR;
          idx_q <= 4'h0;
        end
      endcase
    end
  end

  // Full-scale code spans about +/-383 Hz at STEP_HZ per unit
  assign OFFSET     = offset_q;
  assign OFFSET_STB = stb_q;
  assign NV_WRITE   = nvw_q;
  assign NV_DATA    = offset_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_hdr_reject: assert property (
    @(posedge CLK) disable iff (RESET)
    (CE && hdr_end && !hdr_ok) |=> st_q == fosc_pkg::ST_HDR && idx_q == 4'h0)
    else $error("bad header check not dropped");
  chk_apply_save: assert property (
    @(posedge CLK) disable iff (RESET)
    (CE && data_end && hdr_ok) |=> OFFSET_STB && OFFSET == $past(data_q))
    else $error("valid offset not applied");
  chk_temp_nosave: assert property (
    @(posedge CLK) disable iff (RESET)
    (OFFSET_STB && hdr_q.cmd == fosc_pkg::CMD_SET_TEMP) |-> !NV_WRITE)
    else $error("non-saving command wrote memory");
  chk_nv_pair: assert property (@(posedge CLK) disable iff (RESET)
    NV_WRITE |-> OFFSET_STB && NV_DATA == OFFSET &&
      hdr_q.cmd == fosc_pkg::CMD_SET_SAVE)
    else $error("save request without saving command");
  chk_data_reject: assert property (
    @(posedge CLK) disable iff (RESET)
    (CE && data_end && !hdr_ok) |=> !OFFSET_STB && $stable(OFFSET))
    else $error("bad data check changed offset");
  chk_read_start: assert property (
    @(posedge CLK) disable iff (RESET)
    (CE && hdr_end && hdr_ok && is_read) |=> st_q == fosc_pkg::ST_SEND)
    else $error("read request not answered");
  chk_resp_head: assert property (
    @(posedge CLK) disable iff (RESET)
    (CE && tx_ld && idx_q == 4'h3) |=>
      tx_sh_q[8:1] == fosc_pkg::RESP_CHK && !TX_PIN)
    else $error("answer header check wrong");
  chk_data_len: assert property (@(posedge CLK) disable iff (RESET)
    st_q == fosc_pkg::ST_DATA |-> hdr_q.len == fosc_pkg::LEN_OFS)
    else $error("data phase with wrong length");
  chk_tx_idle: assert property (@(posedge CLK) disable iff (RESET)
    (!tx_busy_q && !$past(tx_busy_q)) |-> TX_PIN)
    else $error("transmit line not idle high");

endmodule : fosc_cmd

// [test/fosc_host.sv]
/*
  Host model: 8N1 serial sender and receiver for the offset interpreter.
  Assumes one device clock and a bit length given in clock cycles.
*/
`timescale 1ns/1ps
module fosc_host #(
  parameter int unsigned BIT_CYC = 16
) (
  input  wire logic CLK,
  input  wire logic RX_LINE,
  output logic      TX_LINE
);
  // ----------------------------------------------------------------
  // Line drivers
  // ----------------------------------------------------------------
  initial TX_LINE = 1'b1;

  // Start, data LSB first, stop, idle high
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge CLK);
      #1 TX_LINE = f[i];
      repeat (BIT_CYC - 1) @(posedge CLK);
    end
  endtask : send_byte

  // Bounded hunt for a start bit, mid-bit sampling
  task automatic recv_byte(output logic [7:0] b, output bit ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (RX_LINE !== 1'b0 && n < 80 * BIT_CYC) begin
      @(negedge CLK);
      n++;
    end
    if (n < 80 * BIT_CYC) begin
      repeat (BIT_CYC / 2) @(posedge CLK);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge CLK);
        #2 b[i] = RX_LINE;
      end
      repeat (BIT_CYC) @(posedge CLK);
      #2 ok = (RX_LINE === 1'b1);
    end
  endtask : recv_byte
endmodule : fosc_host

// [test/tb.sv]
/*
  Self-checking bench for the serial offset interpreter.
  Assumes the host model file is compiled first; CE held high.
*/
`timescale 1ns/1ps
module tb;
  localparam int unsigned BITC = 16;
  logic        clk;
  logic        reset;
  logic        ce;
  logic        rx_pin;
  logic        tx_pin;
  logic [31:0] nv_offset;
  logic [31:0] offset;
  logic        offset_stb;
  logic        nv_write;
  logic [31:0] nv_data;
  logic [31:0] stb_val;
  int          n_fail;
  int          total_checks;
  int          n_stb;
  int          n_nvw;

  fosc_cmd #(.CLKS_PER_BIT(BITC)) uut (.CLK(clk), .RESET(reset),
    .CE(ce), .RX_PIN(rx_pin), .TX_PIN(tx_pin), .NV_OFFSET(nv_offset),
    .OFFSET(offset), .OFFSET_STB(offset_stb), .NV_WRITE(nv_write),
    .NV_DATA(nv_data));
  fosc_host #(.BIT_CYC(BITC)) host (.CLK(clk), .RX_LINE(tx_pin),
    .TX_LINE(rx_pin));

  // ----------------------------------------------------------------
  // Clock, monitor, helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Negedge keeps the strobe sample clear of the launching edge
  always @(negedge clk) begin
    if (offset_stb === 1'b1) begin
      n_stb++;
      stb_val = offset;
    end
    // Nonvolatile store keeps whatever the device saves
    if (nv_write === 1'b1) begin
      n_nvw++;
      nv_offset = nv_data;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  // Header, checks, data MSB first
  // Data count follows the length field
  task automatic send_msg(input logic [7:0] cmd, input logic [15:0] len,
    input logic [31:0] v, input logic [7:0] hx, input logic [7:0] dx);
    logic [7:0] b[9];
    b = '{cmd, len[7:0], len[15:8], cmd ^ len[7:0] ^ len[15:8] ^ hx,
          v[31:24], v[23:16], v[15:8], v[7:0],
          v[31:24] ^ v[23:16] ^ v[15:8] ^ v[7:0] ^ dx};
    for (int i = 0; i < ((len == 16'h0009) ? 9 : 4); i++) begin
      host.send_byte(b[i]);
    end
  endtask : send_msg

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_set(input logic [7:0] cmd, input logic [31:0] v);
    int s0;
    int w0;
    s0 = n_stb;
    w0 = n_nvw;
    send_msg(cmd, 16'h0009, v, 8'h00, 8'h00);
    repeat (3 * BITC) @(posedge clk);
    check(32'(n_stb - s0), 32'h0000_0001);
    check(stb_val, v);
    check(offset, v);
    check(32'(n_nvw - w0), {31'h0, cmd == 8'h2C});
    if (cmd == 8'h2C) check(nv_data, v);
  endtask : t_set

  // Wrong header check, unknown code, wrong length, wrong data check: all dropped
  task automatic t_bad;
    int s0;
    s0 = n_stb;
    send_msg(8'h2D, 16'h0004, 32'h0000_0000, 8'h01, 8'h00);
    send_msg(8'h2F, 16'h0004, 32'h0000_0000, 8'h00, 8'h00);
    send_msg(8'h2E, 16'h0004, 32'h0000_0000, 8'h00, 8'h00);
    send_msg(8'h2E, 16'h0009, 32'h5555_5555, 8'h00, 8'h01);
    repeat (3 * BITC) @(posedge clk);
    check(32'(n_stb - s0), 32'h0000_0000);
    check(offset, 32'h7FFF_FFFF);
    check({31'h0, tx_pin}, 32'h0000_0001);
  endtask : t_bad

  task automatic t_read;
    logic [7:0] exp[9];
    logic [7:0] got;
    bit         ok;
    exp = '{8'h2D, 8'h09, 8'h00, 8'h24, 8'h7F, 8'hFF, 8'hFF, 8'hFF,
            8'h80};
    fork
      send_msg(8'h2D, 16'h0004, 32'h0000_0000, 8'h00, 8'h00);
      for (int i = 0; i < 9; i++) begin
        host.recv_byte(got, ok);
        check({24'h0, got}, {24'h0, exp[i]});
        check({31'h0, ok}, 32'h0000_0001);
      end
    join
  endtask : t_read

  // Power cycle: only the saved offset comes back
  task automatic t_reset;
    t_set(8'h2E, 32'h0123_4567);
    @(posedge clk);
    #1 reset = 1'b1;
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk);
    check(offset, 32'h7FFF_FFFF);
    check(nv_data, 32'h7FFF_FFFF);
    check({31'h0, tx_pin}, 32'h0000_0001);
  endtask : t_reset

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0;
    total_checks = 0;
    n_stb = 0;
    n_nvw = 0;
    stb_val = 32'h0000_0000;
    reset = 1'b1;
    ce = 1'b1;
    nv_offset = 32'h1234_5678;
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk);
    check(offset, 32'h1234_5678);
    check({31'h0, tx_pin}, 32'h0000_0001);
    t_set(8'h2E, 32'h8000_0000);
    t_set(8'h2E, 32'h0000_0001);
    t_set(8'h2C, 32'h7FFF_FFFF); // One save per run
    t_bad;
    t_read;
    t_reset;
    report_and_stop;
  end

  // Whole run needs well under a millisecond
  initial begin
    #2_000_000;
    n_fail++;
    report_and_stop;
  end
endmodule : tb
